// [bench/asio_far_model.sv]
// encoder and sensor model at the far side of the axis block
`timescale 1ns/1ns
module asio_far_model #(
  parameter int NUM_AXES = 4
) (
  // clock
  input wire logic core_clk,
  // pins toward the block; every axis sees the same levels
  output logic [NUM_AXES-1:0] encA, encB, fwdLimit, revLimit, nearOrigin,
  output logic [NUM_AXES-1:0] origin, encIndex, inPosition, servoFault
);
  logic phA = 1'b0;
  logic phB = 1'b0;
  // fault, in-position, index, origin, near, reverse, forward; high is idle for low-active
  logic [6:0] sens = 7'h7f;
  assign encA = {NUM_AXES{phA}};
  assign encB = {NUM_AXES{phB}};
  assign {servoFault, inPosition, encIndex, origin, nearOrigin, revLimit, fwdLimit} =
    {{NUM_AXES{sens[6]}}, {NUM_AXES{sens[5]}}, {NUM_AXES{sens[4]}}, {NUM_AXES{sens[3]}},
    {NUM_AXES{sens[2]}}, {NUM_AXES{sens[1]}}, {NUM_AXES{sens[0]}}};
  task automatic setSens(input logic [6:0] v);
    @(posedge core_clk);
    sens <= v;
  endtask
  // gap sets shaft speed: small is prompt, large is slow
  task automatic quad(input int n, input bit rev, input int gap);
    logic [1:0] fwdSeq [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
    logic [1:0] revSeq [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
    for (int i = 0; i < 4 * n; i++) begin
      repeat (gap) @(posedge core_clk);
      {phA, phB} <= rev ? revSeq[i % 4] : fwdSeq[i % 4];
    end
  endtask
  task automatic updn(input int n, input bit down, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(posedge core_clk);
      {phA, phB} <= down ? 2'b01 : 2'b10;
      repeat (gap) @(posedge core_clk);
      {phA, phB} <= 2'b00;
    end
  endtask
endmodule

// [bench/asio_top_properties.sv]
// port-level assertions for the axis signal conditioning block
`timescale 1ns/1ns
module asio_top_properties #(
  parameter int NUM_AXES = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // pins, grouped to save space
  input wire logic [NUM_AXES-1:0] encA, encB, fwdLimit, revLimit, nearOrigin,
  input wire logic [NUM_AXES-1:0] origin, encIndex, inPosition, servoFault,
  input wire logic [NUM_AXES-1:0] pulseA, pulseB, drvEnable,
  input wire logic irq
);
  // shadow of axis 0 settings so pin polarity can be judged here
  logic [15:0] cfg0_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg0_r <= 16'h0000;
    end else if (wr && addr == 8'h00) begin
      cfg0_r <= wdata[15:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside the answer cycle");
  a_drv_enable: assert property (wr && addr == 8'h00 |-> ##2 drvEnable[0] == $past(wdata[15], 2))
    else $error("driver enable does not follow its setting");
  a_axis_isolation: assert property (wr && addr[7:4] != 4'h0 |-> ##2 $stable(drvEnable[0]))
    else $error("axis 0 driver enable moved on another write");
  a_limit_halt: assert property (((fwdLimit[0] == cfg0_r[5] || revLimit[0] == cfg0_r[6])
    && !cfg0_r[14] && !wr)[*8] |=> ##1 $stable(pulseA[0]) && $stable(pulseB[0]))
    else $error("pulses continue under an active limit");
  a_ccw_exclusive: assert property ($past(cfg0_r[1:0]) == 2'b00 && cfg0_r[1:0] == 2'b00
    |-> !(pulseA[0] && pulseB[0]))
    else $error("both pulse trains active at once");
  a_dir_level: assert property (wr && addr == 8'h04 && cfg0_r[0]
    |-> ##2 pulseB[0] == ($past(wdata[17], 2) ^ cfg0_r[2]))
    else $error("direction level wrong");
  a_status_polarity: assert property (($stable({servoFault[0], inPosition[0], encIndex[0],
    origin[0], nearOrigin[0], revLimit[0], fwdLimit[0]}) && $stable(cfg0_r))[*8] ##0 (rd && addr == 8'h0c)
    |=> rdata[8:2] == {cfg0_r[12] && (servoFault[0] == cfg0_r[13]), cfg0_r[10] && (inPosition[0] == cfg0_r[11]),
    encIndex[0] == cfg0_r[9], origin[0] == cfg0_r[8], nearOrigin[0] == cfg0_r[7],
    revLimit[0] == cfg0_r[6], fwdLimit[0] == cfg0_r[5]})
    else $error("status bits disagree with pin polarity");
  a_irq_masked: assert property (wr && addr == 8'h84 && wdata == 32'h0 |=> !irq)
    else $error("interrupt high with all sources masked");
  cover property ($rose(irq));
  cover property (wr && addr == 8'h04 && cfg0_r[0]);
  cover property (rd && addr == 8'h0c);
endmodule

bind asio_top asio_top_properties #(.NUM_AXES(NUM_AXES)) asio_top_properties_inst (.*);

// [bench/tb_axis_signal_io_config.sv]
// self-checking bench for the axis signal conditioning block
`timescale 1ns/1ns
module tb_axis_signal_io_config;
  localparam int NA = 4;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [NA-1:0] encA, encB, fwdLimit, revLimit, nearOrigin, origin, encIndex, inPosition, servoFault;
  logic [NA-1:0] pulseA, pulseB, drvEnable;
  logic irq;
  int fails = 0;
  int nChecks = 0;
  asio_top #(.NUM_AXES(NA)) asio_top_inst (.*);
  asio_far_model #(.NUM_AXES(NA)) asio_far_model_inst (.*);
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // answer stands only in the cycle after the strobe, so sample mid-cycle
  task automatic readCheck(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    check(what, exp, rdata);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic runCount(input logic [31:0] motion, output int ca, output int cb);
    logic pa;
    logic pb;
    regWrite(8'h04, motion);
    settle(2);
    pa = pulseA[0];
    pb = pulseB[0];
    ca = 0;
    cb = 0;
    repeat (32) begin
      @(negedge core_clk);
      ca += int'(pulseA[0] !== pa);
      cb += int'(pulseB[0] !== pb);
      pa = pulseA[0];
      pb = pulseB[0];
    end
    regWrite(8'h04, 32'h4);
    settle(3);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic testResetValues;
    readCheck("cfg0", 8'h00, 32'h0);
    readCheck("motion0", 8'h04, 32'h64);
    readCheck("pos0", 8'h08, 32'h0);
    readCheck("irqStatus", 8'h80, 32'h0);
    readCheck("unmapped", 8'h40, 32'h0);
    check("drvEnable", 32'h0, {28'h0, drvEnable});
  endtask
  task automatic testEncoder;
    int mult [4] = '{1, 2, 4, 1};
    for (int m = 0; m < 4; m++) begin
      regWrite(8'h00, 32'(m) << 3);
      regWrite(8'h08, 32'h0);
      if (m == 3) asio_far_model_inst.updn(3, 1'b0, 3);
      else asio_far_model_inst.quad(3, 1'b0, 3);
      settle(8);
      readCheck("posForward", 8'h08, 32'(3 * mult[m]));
      if (m == 3) asio_far_model_inst.updn(1, 1'b1, 3);
      else asio_far_model_inst.quad(1, 1'b1, 2);
      settle(8);
      readCheck("posReverse", 8'h08, 32'(2 * mult[m]));
    end
  endtask
  task automatic testSensors;
    asio_far_model_inst.setSens(7'h55);
    regWrite(8'h00, 32'h3fe0);
    regWrite(8'h10, 32'h1400);
    settle(10);
    readCheck("statHighLevels", 8'h0c, 32'h154);
    readCheck("statOtherAxis", 8'h1c, 32'h0a8);
    regWrite(8'h00, 32'h2be0);
    settle(10);
    readCheck("statDisabled", 8'h0c, 32'h054);
    asio_far_model_inst.setSens(7'h2a);
    settle(10);
    readCheck("statDisabledLow", 8'h0c, 32'h028);
    readCheck("statOtherLow", 8'h1c, 32'h154);
    asio_far_model_inst.setSens(7'h7f);
    regWrite(8'h10, 32'h0);
  endtask
  task automatic testPulseOut;
    int ca;
    int cb;
    for (int k = 0; k < 4; k++) begin
      regWrite(8'h00, 32'h8001 | (32'(k) << 1));
      runCount(32'h30004, ca, cb);
      check("pdPulses", 32'd8, 32'(ca));
      check("pdDirSteady", 32'd0, 32'(cb));
      check("pdIdle", 32'(k & 1), {31'h0, pulseA[0]});
      check("pdDirLevel", 32'(k >> 1), {31'h0, pulseB[0]});
      check("drvOn", 32'h1, {31'h0, drvEnable[0]});
    end
    for (int d = 0; d < 2; d++) begin
      regWrite(8'h00, 32'h8000);
      runCount(32'h10004 | (32'(d) << 17), ca, cb);
      check("cwPulses", d ? 32'd0 : 32'd8, 32'(ca));
      check("ccwPulses", d ? 32'd8 : 32'd0, 32'(cb));
    end
  endtask
  task automatic testLimits;
    regWrite(8'h84, 32'h1);
    regWrite(8'h00, 32'h8000);
    regWrite(8'h04, 32'h10002);
    asio_far_model_inst.setSens(7'h7e);
    settle(10);
    check("irqImmediate", 32'h1, {31'h0, irq});
    readCheck("motionStopped", 8'h04, 32'h2);
    readCheck("irqStatus", 8'h80, 32'h1);
    regWrite(8'h80, 32'h1);
    settle(0);
    check("irqCleared", 32'h0, {31'h0, irq});
    asio_far_model_inst.setSens(7'h7f);
    regWrite(8'h00, 32'hc000);
    regWrite(8'h04, 32'h10002);
    settle(4);
    asio_far_model_inst.setSens(7'h7d);
    settle(40);
    readCheck("statDecel", 8'h0c, 32'h608);
    readCheck("decelPeriod", 8'h04, 32'h10042);
    readCheck("irqDecel", 8'h80, 32'h1);
    regWrite(8'h84, 32'h0);
    settle(0);
    check("irqMasked", 32'h0, {31'h0, irq});
    regWrite(8'h04, 32'h4);
    asio_far_model_inst.setSens(7'h7f);
  endtask
  task automatic testFault;
    regWrite(8'h80, 32'h1);
    regWrite(8'h00, 32'h9000);
    regWrite(8'h04, 32'h10002);
    asio_far_model_inst.setSens(7'h3f);
    settle(10);
    readCheck("faultStopped", 8'h04, 32'h2);
    readCheck("faultIrqStatus", 8'h80, 32'h2);
    regWrite(8'h00, 32'h8000);
    regWrite(8'h04, 32'h10002);
    settle(6);
    readCheck("faultIgnored", 8'h04, 32'h10002);
    regWrite(8'h04, 32'h4);
    asio_far_model_inst.setSens(7'h7f);
  endtask
  // ----------------------------------------
  // sequence, verdict and watchdog
  // ----------------------------------------
  task automatic printVerdict;
    if (fails == 0 && nChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= 8'h00;
    wdata <= 32'h0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    testResetValues();
    testEncoder();
    testSensors();
    testPulseOut();
    testLimits();
    testFault();
    printVerdict();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    printVerdict();
  end
endmodule

// [hw/asio_defs.svh]
// constants for the per-axis signal conditioning block
//
// Summary of operation
// - quadrature mode: count up when A leads B, down when B leads A
// - single-edge multiplier: count only rising edges of phase A
// - double-edge multiplier: count rising and falling edges of phase A
// - quadruple multiplier: count every edge of phase A and phase B
// - up/down mode: rising edge on A counts up, on B counts down
// - step output as CW/COUNTERCLOCKWISE_PULSE_TRAIN or pulse/dir, edge and direction polarity selectable
// - per-axis driver enable output under software control
// - forward and reverse limits each have their own active level
// - near-origin input active low at level 0, high at level 1
// - origin input active low or high per axis level setting
// - index input active low or high per axis level setting
// - immediate limit mode: pulses stop at once on any active limit
// - decelerating limit mode: speed ramps down to standstill on any limit
// - in-position input ignored unless enabled, with its own active level
// - servo fault input ignored unless enabled, with its own active level
`ifndef ASIO_DEFS_SVH
`define ASIO_DEFS_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define ASIO_MAX_AXES 8
`define ASIO_NUM_AXES 4
`define ASIO_NUM_IN 9
`define ASIO_CFG_W 16

// ----------------------------------------
// register word indices within an axis, interrupt register byte offsets
// ----------------------------------------
`define ASIO_OFF_CFG 2'h0
`define ASIO_OFF_MOTION 2'h1
`define ASIO_OFF_POS 2'h2
`define ASIO_OFF_STAT 2'h3
`define ASIO_OFF_IRQ_ST 8'h80
`define ASIO_OFF_IRQ_MASK 8'h84

// ----------------------------------------
// config fields
// ----------------------------------------
`define ASIO_CFG_PDIR 0
`define ASIO_CFG_FALL 1
`define ASIO_CFG_DIRINV 2
`define ASIO_CFG_ENC_LO 3
`define ASIO_CFG_ENC_HI 4
`define ASIO_CFG_FWD_LVL 5
`define ASIO_CFG_REV_LVL 6
`define ASIO_CFG_NEAR_LVL 7
`define ASIO_CFG_ORG_LVL 8
`define ASIO_CFG_IDX_LVL 9
`define ASIO_CFG_INP_EN 10
`define ASIO_CFG_INP_LVL 11
`define ASIO_CFG_FLT_EN 12
`define ASIO_CFG_FLT_LVL 13
`define ASIO_CFG_HALT_DECEL 14
`define ASIO_CFG_DRV_EN 15
`define ASIO_CFG_RST 16'h0000

// ----------------------------------------
// motion fields and ramp
// ----------------------------------------
`define ASIO_MOT_RUN 16
`define ASIO_MOT_DIR 17
`define ASIO_PERIOD_RST 16'h0064
`define ASIO_DECEL_INC 16'h0040
`define ASIO_STOP_PERIOD 16'hf000

// ----------------------------------------
// input vector positions
// ----------------------------------------
`define ASIO_IN_A 0
`define ASIO_IN_B 1
`define ASIO_IN_FWD 2
`define ASIO_IN_REV 3
`define ASIO_IN_NEAR 4
`define ASIO_IN_ORG 5
`define ASIO_IN_IDX 6
`define ASIO_IN_INP 7
`define ASIO_IN_FLT 8

`endif

// [hw/asio_pkg.sv]
// types of the per-axis signal conditioning block
`include "asio_defs.svh"
package asio_pkg;

  typedef enum logic [1:0] {ENC_X1, ENC_X2, ENC_X4, ENC_UPDN} asio_enc_t;

  typedef enum logic [1:0] {MOT_IDLE, MOT_RUN, MOT_DECEL} asio_mot_t;

  typedef struct packed {
    logic [`ASIO_CFG_W-1:0] cfg;
    logic [15:0] period;
    logic dir;
    asio_mot_t mot;
    logic [15:0] timer;
    logic phase;
    logic [31:0] pos;
    logic [`ASIO_NUM_IN-1:0] s1;
    logic [`ASIO_NUM_IN-1:0] s2;
    logic [`ASIO_NUM_IN-1:0] s3;
    logic [`ASIO_NUM_IN-1:0] filt;
    logic outA;
    logic outB;
    logic drvEn;
  } asio_axis_t;

  typedef struct packed {
    asio_axis_t [`ASIO_MAX_AXES-1:0] ax;
    logic [2*`ASIO_MAX_AXES-1:0] irqSt;
    logic [2*`ASIO_MAX_AXES-1:0] irqMask;
    logic [31:0] rdata;
  } asio_state_t;

endpackage

// [hw/asio_top.sv]
// per-axis pulse output, encoder counter and sensor conditioning
`timescale 1ns/1ns
`include "asio_defs.svh"
module asio_top
  import asio_pkg::*;
#(
  parameter int NUM_AXES = `ASIO_NUM_AXES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // encoder and sensor pins, one bit per axis
  input wire logic [NUM_AXES-1:0] encA,
  input wire logic [NUM_AXES-1:0] encB,
  input wire logic [NUM_AXES-1:0] fwdLimit,
  input wire logic [NUM_AXES-1:0] revLimit,
  input wire logic [NUM_AXES-1:0] nearOrigin,
  input wire logic [NUM_AXES-1:0] origin,
  input wire logic [NUM_AXES-1:0] encIndex,
  input wire logic [NUM_AXES-1:0] inPosition,
  input wire logic [NUM_AXES-1:0] servoFault,
  // drive pins, one bit per axis
  output logic [NUM_AXES-1:0] pulseA,
  output logic [NUM_AXES-1:0] pulseB,
  output logic [NUM_AXES-1:0] drvEnable,
  // interrupt
  output logic irq
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (NUM_AXES < 1 || NUM_AXES > `ASIO_MAX_AXES) begin : g_bad
    $error("NUM_AXES out of range");
  end

  asio_state_t s_r;
  asio_state_t s_nxt;
  logic [`ASIO_MAX_AXES-1:0][`ASIO_NUM_IN-1:0] rawIn;
  logic [`ASIO_MAX_AXES-1:0][10:0] stat;
  logic [2*`ASIO_MAX_AXES-1:0] irqEv;
  logic [2*`ASIO_MAX_AXES-1:0] irqClr;

  // polarity: level 1 means active high
  function automatic logic asserted(input logic lvl, input logic pin);
    asserted = lvl ? pin : ~pin;
  endfunction

  // ----------------------------------------
  // pin gathering
  // ----------------------------------------
  for (genvar g = 0; g < `ASIO_MAX_AXES; g++) begin : g_pin
    if (g < NUM_AXES) begin : g_used
      assign rawIn[g] = {servoFault[g], inPosition[g], encIndex[g], origin[g], nearOrigin[g],
                         revLimit[g], fwdLimit[g], encB[g], encA[g]};
      assign pulseA[g] = s_r.ax[g].outA;
      assign pulseB[g] = s_r.ax[g].outB;
      assign drvEnable[g] = s_r.ax[g].drvEn;
    end else begin : g_unused
      assign rawIn[g] = '0;
    end
  end

  assign rdata = s_r.rdata;
  assign irq = |(s_r.irqSt & s_r.irqMask);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [`ASIO_CFG_W-1:0] c;
    logic [`ASIO_NUM_IN-1:0] f;
    logic [`ASIO_NUM_IN-1:0] fp;
    logic [`ASIO_NUM_IN-1:0] agree;
    logic aR, aF, bR, bF, up, dn, lim, flt, tick, pl, idle, effDir, hit;
    c = '0;
    f = '0;
    fp = '0;
    agree = '0;
    aR = 1'b0;
    aF = 1'b0;
    bR = 1'b0;
    bF = 1'b0;
    up = 1'b0;
    dn = 1'b0;
    lim = 1'b0;
    flt = 1'b0;
    tick = 1'b0;
    pl = 1'b0;
    idle = 1'b0;
    effDir = 1'b0;
    hit = 1'b0;
    s_nxt = s_r;
    s_nxt.rdata = '0;
    irqEv = '0;
    stat = '0;
    irqClr = (wr && addr == `ASIO_OFF_IRQ_ST) ? wdata[2*`ASIO_MAX_AXES-1:0] : '0;

    for (int i = 0; i < NUM_AXES; i++) begin
      c = s_r.ax[i].cfg;
      hit = ~addr[7] && (addr[6:4] == 3'(i));

      // three-stage sync, value taken once stages two and three agree
      s_nxt.ax[i].s1 = rawIn[i];
      s_nxt.ax[i].s2 = s_r.ax[i].s1;
      s_nxt.ax[i].s3 = s_r.ax[i].s2;
      agree = s_r.ax[i].s2 ~^ s_r.ax[i].s3;
      s_nxt.ax[i].filt = (agree & s_r.ax[i].s3) | (~agree & s_r.ax[i].filt);
      f = s_nxt.ax[i].filt;
      fp = s_r.ax[i].filt;

      // encoder edges
      aR = f[`ASIO_IN_A] & ~fp[`ASIO_IN_A];
      aF = ~f[`ASIO_IN_A] & fp[`ASIO_IN_A];
      bR = f[`ASIO_IN_B] & ~fp[`ASIO_IN_B];
      bF = ~f[`ASIO_IN_B] & fp[`ASIO_IN_B];
      case (asio_enc_t'(c[`ASIO_CFG_ENC_HI:`ASIO_CFG_ENC_LO]))
        ENC_X1: begin
          up = aR & ~f[`ASIO_IN_B];
          dn = aR & f[`ASIO_IN_B];
        end
        ENC_X2: begin
          up = (aR & ~f[`ASIO_IN_B]) | (aF & f[`ASIO_IN_B]);
          dn = (aR & f[`ASIO_IN_B]) | (aF & ~f[`ASIO_IN_B]);
        end
        ENC_X4: begin
          up = (aR & ~f[`ASIO_IN_B]) | (aF & f[`ASIO_IN_B])
             | (bR & f[`ASIO_IN_A]) | (bF & ~f[`ASIO_IN_A]);
          dn = (aR & f[`ASIO_IN_B]) | (aF & ~f[`ASIO_IN_B])
             | (bR & ~f[`ASIO_IN_A]) | (bF & f[`ASIO_IN_A]);
        end
        ENC_UPDN: begin
          up = aR;
          dn = bR;
        end
        default: begin
          up = 1'b0;
          dn = 1'b0;
        end
      endcase

      // a load from software does not swallow a count in the same cycle
      if (wr && hit && addr[3:2] == `ASIO_OFF_POS) begin
        s_nxt.ax[i].pos = wdata;
      end
      if (up && !dn) begin
        s_nxt.ax[i].pos = s_nxt.ax[i].pos + 32'h0000_0001;
      end else if (dn && !up) begin
        s_nxt.ax[i].pos = s_nxt.ax[i].pos - 32'h0000_0001;
      end

      // conditioned inputs, all active high from here on
      lim = asserted(c[`ASIO_CFG_FWD_LVL], fp[`ASIO_IN_FWD])
          | asserted(c[`ASIO_CFG_REV_LVL], fp[`ASIO_IN_REV]);
      flt = c[`ASIO_CFG_FLT_EN] & asserted(c[`ASIO_CFG_FLT_LVL], fp[`ASIO_IN_FLT]);
      stat[i] = {s_r.ax[i].mot == MOT_DECEL, s_r.ax[i].mot != MOT_IDLE, flt,
                 c[`ASIO_CFG_INP_EN] & asserted(c[`ASIO_CFG_INP_LVL], fp[`ASIO_IN_INP]),
                 asserted(c[`ASIO_CFG_IDX_LVL], fp[`ASIO_IN_IDX]),
                 asserted(c[`ASIO_CFG_ORG_LVL], fp[`ASIO_IN_ORG]),
                 asserted(c[`ASIO_CFG_NEAR_LVL], fp[`ASIO_IN_NEAR]),
                 asserted(c[`ASIO_CFG_REV_LVL], fp[`ASIO_IN_REV]),
                 asserted(c[`ASIO_CFG_FWD_LVL], fp[`ASIO_IN_FWD]),
                 fp[`ASIO_IN_B], fp[`ASIO_IN_A]};

      // step timer: half period of period cycles at least one
      tick = ({1'b0, s_r.ax[i].timer} + 17'h0_0001) >= {1'b0, s_r.ax[i].period};
      case (s_r.ax[i].mot)
        MOT_IDLE: begin
          s_nxt.ax[i].timer = '0;
          s_nxt.ax[i].phase = 1'b0;
        end
        MOT_RUN, MOT_DECEL: begin
          if (tick) begin
            s_nxt.ax[i].timer = '0;
            s_nxt.ax[i].phase = ~s_r.ax[i].phase;
            if (s_r.ax[i].phase && s_r.ax[i].mot == MOT_DECEL) begin
              // ramp by stretching the period after each whole pulse
              if (s_r.ax[i].period >= `ASIO_STOP_PERIOD - `ASIO_DECEL_INC) begin
                s_nxt.ax[i].mot = MOT_IDLE;
              end else begin
                s_nxt.ax[i].period = s_r.ax[i].period + `ASIO_DECEL_INC;
              end
            end
          end else begin
            s_nxt.ax[i].timer = s_r.ax[i].timer + 16'h0001;
          end
        end
        default: begin
          s_nxt.ax[i].mot = MOT_IDLE;
        end
      endcase

      // fault beats the limit handling and always stops at once
      if (s_r.ax[i].mot != MOT_IDLE) begin
        if (flt) begin
          s_nxt.ax[i].mot = MOT_IDLE;
          s_nxt.ax[i].phase = 1'b0;
          irqEv[2*i+1] = 1'b1;
        end else if (lim && s_r.ax[i].mot == MOT_RUN) begin
          irqEv[2*i] = 1'b1;
          if (c[`ASIO_CFG_HALT_DECEL]) begin
            s_nxt.ax[i].mot = MOT_DECEL;
          end else begin
            s_nxt.ax[i].mot = MOT_IDLE;
            s_nxt.ax[i].phase = 1'b0;
          end
        end
      end

      // software writes, per axis only
      if (wr && hit && addr[3:2] == `ASIO_OFF_CFG) begin
        s_nxt.ax[i].cfg = wdata[`ASIO_CFG_W-1:0];
      end
      if (wr && hit && addr[3:2] == `ASIO_OFF_MOTION) begin
        s_nxt.ax[i].period = wdata[15:0];
        s_nxt.ax[i].dir = wdata[`ASIO_MOT_DIR];
        s_nxt.ax[i].timer = '0;
        s_nxt.ax[i].phase = 1'b0;
        s_nxt.ax[i].mot = wdata[`ASIO_MOT_RUN] ? MOT_RUN : MOT_IDLE;
      end

      // pin formatting from current state; a cycle of lag, glitch free
      idle = c[`ASIO_CFG_FALL];
      pl = s_r.ax[i].phase ^ c[`ASIO_CFG_FALL];
      effDir = s_r.ax[i].dir ^ c[`ASIO_CFG_DIRINV];
      if (c[`ASIO_CFG_PDIR]) begin
        s_nxt.ax[i].outA = pl;
        s_nxt.ax[i].outB = effDir;
      end else begin
        s_nxt.ax[i].outA = effDir ? idle : pl;
        s_nxt.ax[i].outB = effDir ? pl : idle;
      end
      s_nxt.ax[i].drvEn = c[`ASIO_CFG_DRV_EN];
    end

    // sticky status: a new event wins over a clear in the same cycle
    s_nxt.irqSt = (s_r.irqSt & ~irqClr) | irqEv;
    if (wr && addr == `ASIO_OFF_IRQ_MASK) begin
      s_nxt.irqMask = wdata[2*`ASIO_MAX_AXES-1:0];
    end

    // read data, valid only in the cycle after the strobe
    if (rd) begin
      if (addr == `ASIO_OFF_IRQ_ST) begin
        s_nxt.rdata = 32'(s_r.irqSt);
      end else if (addr == `ASIO_OFF_IRQ_MASK) begin
        s_nxt.rdata = 32'(s_r.irqMask);
      end else if (!addr[7] && addr[1:0] == 2'h0 && 32'(addr[6:4]) < NUM_AXES) begin
        case (addr[3:2])
          `ASIO_OFF_CFG: s_nxt.rdata = 32'(s_r.ax[addr[6:4]].cfg);
          `ASIO_OFF_MOTION: s_nxt.rdata = {14'h0000, s_r.ax[addr[6:4]].dir,
                                           s_r.ax[addr[6:4]].mot != MOT_IDLE, s_r.ax[addr[6:4]].period};
          `ASIO_OFF_POS: s_nxt.rdata = s_r.ax[addr[6:4]].pos;
          `ASIO_OFF_STAT: s_nxt.rdata = 32'(stat[addr[6:4]]);
          default: s_nxt.rdata = '0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      for (int i = 0; i < `ASIO_MAX_AXES; i++) begin
        s_r.ax[i].cfg <= `ASIO_CFG_RST;
        s_r.ax[i].period <= `ASIO_PERIOD_RST;
        s_r.ax[i].mot <= MOT_IDLE;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule
